// ===== logic/mini_uart_params.svh
// offsets, field positions, reset values and sizes of the mini uart
`ifndef MINI_UART_PARAMS_SVH
`define MINI_UART_PARAMS_SVH

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define OFF_DATA 8'h00
`define OFF_IER 8'h04
`define OFF_IID 8'h08
`define OFF_LCR 8'h0c
`define OFF_MCR 8'h10
`define OFF_LSR 8'h14
`define OFF_CNTL 8'h18

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define LCR_DIVISOR_LATCH_ACCESS 7
`define LCR_BRK 6
`define LCR_SIZE 0
`define MCR_RTS 1
`define IID_CLR_RX 1
`define IID_CLR_TX 2
`define IER_RX 1
`define IER_TX 0
`define CNTL_AUTO 2
`define CNTL_LVL_LO 4

// ------------------------------------------------------------------
// reset values and constants
// ------------------------------------------------------------------
`define LCR_RESET 8'h00
`define DIV_RESET 16'h0000
`define LCR_WMASK 8'hc1
`define FIFO_DEPTH 4'h8
`define IID_FIFO_EN 2'h3
`define ID_NONE 2'h0
`define ID_THR 2'h1
`define ID_RXD 2'h2
`define LAST_TICK 3'h7
`define HALF_TICK 3'h3

`endif

// ===== logic/mini_uart_pkg.sv
// types of the mini uart status and control block
`default_nettype none
package mini_uart_pkg;

    // transmit shifter states
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_START = 2'b01,
        TX_DATA = 2'b10,
        TX_STOP = 2'b11
    } tx_st_t;

    // receive sampler states
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_TAIL = 2'b11
    } rx_st_t;

    // whole state of the block
    typedef struct packed {
        logic [7:0][7:0] txm;
        logic [2:0] txw;
        logic [2:0] txr;
        logic [3:0] txc;
        logic [7:0][7:0] rxm;
        logic [2:0] rxw;
        logic [2:0] rxr;
        logic [3:0] rxc;
        logic [15:0] div;
        logic [15:0] bcnt;
        logic [1:0] ier;
        logic [7:0] lcr;
        logic mcr_rts;
        logic auto_rts;
        logic [1:0] lvl;
        logic ov;
        tx_st_t txs;
        logic [2:0] txo;
        logic [2:0] txb;
        logic [7:0] txsh;
        rx_st_t rxs;
        logic [2:0] rxo;
        logic [2:0] rxb;
        logic [7:0] rxsh;
        logic rdy;
        logic err;
        logic [31:0] rdat;
        logic txd;
        logic rts;
        logic irq;
    } state_t;

endpackage : mini_uart_pkg
`default_nettype wire

// ===== logic/mini_uart.sv
// mini uart: apb registers, fifos, shifters, status and handshake
`timescale 1ns/1ns
`default_nettype none
`include "mini_uart_params.svh"

module mini_uart
    import mini_uart_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // serial peer
    input wire logic serial_receive_in_i,
    output logic serial_transmit_out_o,
    output logic request_to_send_out_o,
    // interrupt request, level
    output logic irq_o
);

    // ------------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------------
    state_t s_q; // present state
    state_t s_d; // next state

    // ------------------------------------------------------------------
    // next state logic
    // ------------------------------------------------------------------
    // bus, fifos, shifters and outputs in one pass
    always_comb begin
        logic tick;
        logic acc;
        logic fin;
        logic wr;
        logic rd;
        logic divisor_latch_access;
        logic [2:0] last;
        logic tx_push;
        logic tx_pop;
        logic rx_push;
        logic rx_pop;
        logic ov_set;
        logic ov_clr;
        logic rx_int;
        logic tx_int;
        logic [1:0] id;
        logic line;
        logic [3:0] free;
        logic [3:0] thr;
        logic [31:0] rv;
        logic bad;
        s_d = s_q;
        tick = (s_q.bcnt >= s_q.div); // no long stall when div drops
        acc = psel_i & penable_i;
        fin = acc & s_q.rdy;
        wr = fin & pwrite_i;
        rd = fin & ~pwrite_i;
        divisor_latch_access = s_q.lcr[`LCR_DIVISOR_LATCH_ACCESS];
        // last data bit index, 7 or 8 bit characters
        last = s_q.lcr[`LCR_SIZE] ? 3'h7 : 3'h6;
        tx_push = 1'b0;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_pop = 1'b0;
        ov_set = 1'b0;
        ov_clr = 1'b0;
        rv = 32'h0000_0000;
        bad = 1'b0;

        // oversampling divider, one tick per div+1 cycles
        s_d.bcnt = tick ? 16'h0000 : s_q.bcnt + 16'h0001;

        // interrupt conditions, receive first
        rx_int = s_q.ier[`IER_RX] & (s_q.rxc != 4'h0);
        tx_int = s_q.ier[`IER_TX] & (s_q.txc == 4'h0);
        if (rx_int) begin
            id = `ID_RXD;
        end else if (tx_int) begin
            id = `ID_THR;
        end else begin
            id = `ID_NONE;
        end

        // read mux, sampled in the first access cycle
        case (paddr_i)
            `OFF_DATA: begin
                // divisor low byte or receive head
                rv[7:0] = divisor_latch_access ? s_q.div[7:0] : s_q.rxm[s_q.rxr];
            end
            `OFF_IER: begin
                if (divisor_latch_access) begin
                    rv[7:0] = s_q.div[15:8];
                end else begin
                    rv[1:0] = s_q.ier;
                end
            end
            `OFF_IID: begin
                rv[7:6] = `IID_FIFO_EN;
                rv[5:3] = 3'h0;
                rv[2:1] = id;
                rv[0] = ~(rx_int | tx_int);
            end
            `OFF_LCR: begin
                rv[7:0] = s_q.lcr;
            end
            `OFF_MCR: begin
                rv[`MCR_RTS] = s_q.mcr_rts;
            end
            `OFF_LSR: begin
                // idle: fifo empty and shifter done
                rv[6] = (s_q.txc == 4'h0) & (s_q.txs == TX_IDLE);
                rv[5] = (s_q.txc != `FIFO_DEPTH);
                rv[1] = s_q.ov;
                rv[0] = (s_q.rxc != 4'h0);
            end
            `OFF_CNTL: begin
                rv[`CNTL_AUTO] = s_q.auto_rts;
                rv[5:4] = s_q.lvl;
            end
            default: begin
                // unmapped address answers with an error
                bad = 1'b1;
            end
        endcase

        // two cycle apb answer: latch, then complete
        s_d.rdy = acc & ~s_q.rdy;
        if (acc & ~s_q.rdy) begin
            s_d.rdat = pwrite_i ? 32'h0000_0000 : rv;
            s_d.err = bad;
        end

        // register writes at the completing edge
        if (wr) begin
            case (paddr_i)
                `OFF_DATA: begin
                    if (divisor_latch_access) begin
                        s_d.div[7:0] = pwdata_i[7:0];
                    end else begin
                        // full fifo drops the byte
                        tx_push = (s_q.txc != `FIFO_DEPTH);
                    end
                end
                `OFF_IER: begin
                    if (divisor_latch_access) begin
                        s_d.div[15:8] = pwdata_i[7:0];
                    end else begin
                        s_d.ier = pwdata_i[1:0];
                    end
                end
                `OFF_LCR: begin
                    s_d.lcr = pwdata_i[7:0] & `LCR_WMASK;
                end
                `OFF_MCR: begin
                    s_d.mcr_rts = pwdata_i[`MCR_RTS];
                end
                `OFF_CNTL: begin
                    s_d.auto_rts = pwdata_i[`CNTL_AUTO];
                    s_d.lvl = pwdata_i[`CNTL_LVL_LO +: 2];
                end
                default: begin
                    // iid fifo clears handled below; lsr or unmapped: ignored
                end
            endcase
        end

        // reads with side effects
        if (rd & (paddr_i == `OFF_DATA) & ~divisor_latch_access) begin
            rx_pop = (s_q.rxc != 4'h0);
        end
        if (rd & (paddr_i == `OFF_LSR)) begin
            // clear only what this read reported
            ov_clr = s_q.rdat[1];
        end

        // transmit shifter, eight ticks per bit
        if (tick) begin
            case (s_q.txs)
                TX_IDLE: begin
                    if (s_q.txc != 4'h0) begin
                        s_d.txsh = s_q.txm[s_q.txr];
                        tx_pop = 1'b1;
                        s_d.txs = TX_START;
                        s_d.txo = 3'h0;
                    end
                end
                TX_START: begin
                    s_d.txo = s_q.txo + 3'h1;
                    if (s_q.txo == `LAST_TICK) begin
                        s_d.txs = TX_DATA;
                        s_d.txb = 3'h0;
                    end
                end
                TX_DATA: begin
                    s_d.txo = s_q.txo + 3'h1;
                    if (s_q.txo == `LAST_TICK) begin
                        if (s_q.txb == last) begin
                            s_d.txs = TX_STOP;
                        end else begin
                            s_d.txb = s_q.txb + 3'h1;
                        end
                    end
                end
                TX_STOP: begin
                    s_d.txo = s_q.txo + 3'h1;
                    if (s_q.txo == `LAST_TICK) begin
                        s_d.txs = TX_IDLE;
                    end
                end
                default: begin
                    s_d.txs = TX_IDLE;
                end
            endcase
        end

        // receive sampler, mid-bit sampling
        if (tick) begin
            case (s_q.rxs)
                RX_IDLE: begin
                    if (~serial_receive_in_i) begin
                        s_d.rxs = RX_START;
                        s_d.rxo = 3'h0;
                        s_d.rxsh = 8'h00;
                    end
                end
                RX_START: begin
                    s_d.rxo = s_q.rxo + 3'h1;
                    if (s_q.rxo == `HALF_TICK) begin
                        s_d.rxs = RX_DATA;
                        s_d.rxo = 3'h0;
                        s_d.rxb = 3'h0;
                    end
                end
                RX_DATA: begin
                    s_d.rxo = s_q.rxo + 3'h1;
                    if (s_q.rxo == `LAST_TICK) begin
                        s_d.rxsh[s_q.rxb] = serial_receive_in_i;
                        if (s_q.rxb == last) begin
                            rx_push = 1'b1;
                            s_d.rxs = RX_TAIL;
                            s_d.rxo = 3'h0;
                        end else begin
                            s_d.rxb = s_q.rxb + 3'h1;
                        end
                    end
                end
                RX_TAIL: begin
                    // half a bit, then hunt for a start bit
                    s_d.rxo = s_q.rxo + 3'h1;
                    if (s_q.rxo == `HALF_TICK) begin
                        s_d.rxs = RX_IDLE;
                    end
                end
                default: begin
                    s_d.rxs = RX_IDLE;
                end
            endcase
        end

        // receive fifo push, overrun on full
        if (rx_push) begin
            if (s_q.rxc == `FIFO_DEPTH) begin
                ov_set = 1'b1;
            end else begin
                s_d.rxm[s_q.rxw] = s_d.rxsh;
            end
        end
        // overrun flag, a new overrun beats the clear
        s_d.ov = (s_q.ov & ~ov_clr) | ov_set;

        // transmit fifo bookkeeping
        if (tx_push) begin
            s_d.txm[s_q.txw] = pwdata_i[7:0];
            s_d.txw = s_q.txw + 3'h1;
        end
        if (tx_pop) begin
            s_d.txr = s_q.txr + 3'h1;
        end
        s_d.txc = s_q.txc + {3'h0, tx_push} - {3'h0, tx_pop};

        // receive fifo bookkeeping
        if (rx_push & (s_q.rxc != `FIFO_DEPTH)) begin
            s_d.rxw = s_q.rxw + 3'h1;
            s_d.rxc = s_q.rxc + 4'h1 - {3'h0, rx_pop};
        end else begin
            s_d.rxc = s_q.rxc - {3'h0, rx_pop};
        end
        if (rx_pop) begin
            s_d.rxr = s_q.rxr + 3'h1;
        end

        // fifo clear writes win over traffic this cycle
        if (wr & (paddr_i == `OFF_IID)) begin
            if (pwdata_i[`IID_CLR_RX]) begin
                s_d.rxw = 3'h0;
                s_d.rxr = 3'h0;
                s_d.rxc = 4'h0;
            end
            if (pwdata_i[`IID_CLR_TX]) begin
                s_d.txw = 3'h0;
                s_d.txr = 3'h0;
                s_d.txc = 4'h0;
            end
        end

        // transmit line from the next shifter state
        case (s_d.txs)
            TX_START: line = 1'b0;
            TX_DATA: line = s_d.txsh[s_d.txb];
            default: line = 1'b1;
        endcase
        s_d.txd = line & ~s_d.lcr[`LCR_BRK];

        // request to send: auto flow or software bit
        case (s_d.lvl)
            2'h0: thr = 4'h3;
            2'h1: thr = 4'h2;
            2'h2: thr = 4'h1;
            default: thr = 4'h4;
        endcase
        free = `FIFO_DEPTH - s_d.rxc;
        if (s_d.auto_rts) begin
            s_d.rts = (free <= thr);
        end else begin
            s_d.rts = ~s_d.mcr_rts;
        end

        // level interrupt from the next fifo state
        s_d.irq = (s_d.ier[`IER_RX] & (s_d.rxc != 4'h0))
                | (s_d.ier[`IER_TX] & (s_d.txc == 4'h0));
    end

    // ------------------------------------------------------------------
    // state flip-flops
    // ------------------------------------------------------------------
    // asynchronous reset to constants
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_q <= '0;
            s_q.div <= `DIV_RESET;
            s_q.lcr <= `LCR_RESET;
            s_q.txs <= TX_IDLE;
            s_q.rxs <= RX_IDLE;
            s_q.txd <= 1'b1;
            s_q.rts <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs, each straight from a flip-flop
    // ------------------------------------------------------------------
    assign prdata_o = s_q.rdat;
    assign pready_o = s_q.rdy;
    assign pslverr_o = s_q.err;
    assign serial_transmit_out_o = s_q.txd;
    assign request_to_send_out_o = s_q.rts;
    assign irq_o = s_q.irq;

endmodule : mini_uart
`default_nettype wire

// ===== dv/mini_uart_checker.sv
// port assertions for the mini uart
`timescale 1ns/1ns
`default_nettype none
module mini_uart_checker (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // register bus
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // serial side
    input wire logic serial_receive_in_i,
    input wire logic serial_transmit_out_o,
    input wire logic request_to_send_out_o,
    input wire logic irq_o
);
    default clocking dc @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    logic wr_done; // write completing
    logic iid_rd; // identity read completing
    logic lsr_rd; // status read completing
    logic brk_q; // shadow of break bit
    logic rts_q; // shadow of software rts bit
    logic auto_q; // shadow of auto flow bit
    assign wr_done = psel_i && penable_i && pready_o && pwrite_i;
    assign iid_rd = pready_o && !pwrite_i && paddr_i == 8'h08;
    assign lsr_rd = pready_o && !pwrite_i && paddr_i == 8'h14;
    // ----------------------------------------
    // shadows follow completed writes
    // ----------------------------------------
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            brk_q <= 1'b0;
            rts_q <= 1'b0;
            auto_q <= 1'b0;
        end else if (wr_done) begin
            if (paddr_i == 8'h0c) brk_q <= pwdata_i[6];
            if (paddr_i == 8'h10) rts_q <= pwdata_i[1];
            if (paddr_i == 8'h18) auto_q <= pwdata_i[2];
        end
    end
    property p_fifo_en; iid_rd |-> prdata_o[7:6] == 2'h3; endproperty
    a_fifo_en: assert property (p_fifo_en) else $error("fifo bits");
    property p_zero; iid_rd |-> prdata_o[5:3] == 3'h0; endproperty
    a_zero: assert property (p_zero) else $error("zero bits");
    property p_id; iid_rd |-> prdata_o[2:1] != 2'h3; endproperty
    a_id: assert property (p_id) else $error("bad identity");
    property p_pend;
        iid_rd |-> prdata_o[0] == (prdata_o[2:1] == 2'h0);
    endproperty
    a_pend: assert property (p_pend) else $error("pending bit");
    property p_brk; brk_q |-> !serial_transmit_out_o; endproperty
    a_brk: assert property (p_brk) else $error("break line");
    property p_rts;
        !auto_q |-> request_to_send_out_o == !rts_q;
    endproperty
    a_rts: assert property (p_rts) else $error("rts level");
    property p_idle; lsr_rd && prdata_o[6] |-> prdata_o[5]; endproperty
    a_idle: assert property (p_idle) else $error("idle vs room");
    property p_wait;
        $rose(penable_i) && psel_i |=> pready_o ##1 !pready_o;
    endproperty
    a_wait: assert property (p_wait) else $error("ready timing");
    property p_err; pready_o && paddr_i > 8'h18 |-> pslverr_o; endproperty
    a_err: assert property (p_err) else $error("unmapped ok");
    c_iid: cover property (iid_rd && !prdata_o[0]);
    c_ovr: cover property (lsr_rd && prdata_o[1]);
    c_brk: cover property (brk_q);
endmodule : mini_uart_checker
bind mini_uart mini_uart_checker u_chk (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .serial_receive_in_i(serial_receive_in_i),
    .serial_transmit_out_o(serial_transmit_out_o),
    .request_to_send_out_o(request_to_send_out_o), .irq_o(irq_o)
);
`default_nettype wire

// ===== dv/serial_peer.sv
// serial peer: sends frames on rx, decodes frames from tx
`timescale 1ns/1ns
`default_nettype none
module serial_peer (
    // clock
    input wire logic core_clk_i,
    // serial lines
    input wire logic serial_transmit_out_i,
    output logic serial_receive_in_o
);
    int nbits = 8; // data bits per frame
    int cnt = 0; // frames decoded
    logic [7:0] got = 8'h00; // last decoded frame
    logic [7:0] sh; // decode shift
    initial serial_receive_in_o = 1'b1; // idle line high
    // send one frame, eight clocks a bit, lsb first
    task send(input logic [7:0] b);
        int i;
        @(posedge core_clk_i);
        serial_receive_in_o <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        for (i = 0; i < nbits; i++) begin
            serial_receive_in_o <= b[i];
            repeat (8) @(posedge core_clk_i);
        end
        serial_receive_in_o <= 1'b1;
        repeat (10) @(posedge core_clk_i);
    endtask : send
    // decode at mid bit after each falling start edge
    initial begin
        int i;
        forever begin
            @(negedge serial_transmit_out_i);
            repeat (4) @(posedge core_clk_i);
            sh = 8'h00;
            for (i = 0; i < nbits; i++) begin
                repeat (8) @(posedge core_clk_i);
                sh[i] = serial_transmit_out_i;
            end
            got = sh;
            cnt++;
        end
    end
endmodule : serial_peer
`default_nettype wire

// ===== dv/testbench.sv
// self-checking bench for the mini uart
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk = 1'b0; // core clock
    logic rst = 1'b1; // reset
    logic psel = 1'b0; // bus select
    logic penable = 1'b0; // bus enable
    logic pwrite = 1'b0; // bus direction
    logic [7:0] paddr = 8'h00; // bus address
    logic [31:0] pwdata = 32'h0; // bus write data
    logic [31:0] prdata; // bus read data
    logic pready, pslverr, rx, tx, rts, irq; // dut outputs, rx line
    logic [31:0] r; // last read data
    logic e; // last error flag
    int mismatches = 0;
    int checks = 0;
    int i;
    mini_uart u_dut (.core_clk_i(clk), .reset_i(rst), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .serial_receive_in_i(rx),
        .serial_transmit_out_o(tx), .request_to_send_out_o(rts),
        .irq_o(irq));
    serial_peer u_peer (.core_clk_i(clk), .serial_transmit_out_i(tx),
        .serial_receive_in_o(rx));
    initial forever #20 clk = ~clk; // 25 mhz
    // compare and count
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    // pin selectors for the settled level check
    localparam int pin_tx = 0;
    localparam int pin_rts = 1;
    localparam int pin_irq = 2;
    localparam int pin_err = 3;
    // level taken half a cycle after the call, once outputs have settled
    task pin(input int sel, input logic x);
        logic [3:0] v;
        @(negedge clk);
        v = {e, irq, rts, tx};
        chk({31'h0, v[sel]}, {31'h0, x});
    endtask : pin
    // one bus transfer, waits for ready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk(32'h1, 32'h0);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(r, x);
    endtask : rd
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    // send a byte and wait for the peer to decode it
    task txw(input logic [7:0] d, input logic [7:0] x);
        int c0;
        int k;
        c0 = u_peer.cnt;
        wr(8'h00, {24'h0, d});
        k = 0;
        while (u_peer.cnt == c0 && k < 500) begin
            @(posedge clk);
            k++;
        end
        if (k >= 500) chk(32'h1, 32'h0);
        chk({24'h0, u_peer.got}, {24'h0, x});
    endtask : txw
    task wrap_up;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up
    // watchdog
    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        wrap_up();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(8'h08, 32'hc1);
        rd(8'h14, 32'h60);
        rd(8'h0c, 32'h0);
        rd(8'h10, 32'h0);
        pin(pin_rts, 1'b1);
        apb(1'b0, 8'h1c, 32'h0);
        pin(pin_err, 1'b1);
        wr(8'h0c, 32'hff);
        rd(8'h0c, 32'hc1);
        pin(pin_tx, 1'b0);
        wr(8'h00, 32'h0);
        rd(8'h14, 32'h60);
        repeat (96) @(posedge clk);
        wr(8'h0c, 32'h01);
        pin(pin_tx, 1'b1);
        wr(8'h10, 32'h2);
        pin(pin_rts, 1'b0);
        rd(8'h10, 32'h2);
        wr(8'h10, 32'h0);
        pin(pin_rts, 1'b1);
        wr(8'h04, 32'h3);
        rd(8'h08, 32'hc2);
        pin(pin_irq, 1'b1);
        u_peer.send(8'ha5);
        rd(8'h14, 32'h61);
        rd(8'h08, 32'hc4);
        rd(8'h00, 32'ha5);
        wr(8'h04, 32'h0);
        rd(8'h08, 32'hc1);
        pin(pin_irq, 1'b0);
        for (i = 0; i < 9; i++) u_peer.send(8'(i + 1));
        rd(8'h14, 32'h63);
        rd(8'h14, 32'h61);
        wr(8'h08, 32'h2);
        rd(8'h14, 32'h60);
        txw(8'h3c, 8'h3c);
        repeat (20) @(posedge clk);
        rd(8'h14, 32'h60);
        wr(8'h0c, 32'h0);
        u_peer.nbits = 7;
        txw(8'hd5, 8'h55);
        for (i = 0; i < 10; i++) wr(8'h00, 32'h11);
        rd(8'h14, 32'h0);
        wr(8'h08, 32'h4);
        rd(8'h14, 32'h20);
        repeat (100) @(posedge clk);
        wr(8'h10, 32'h2);
        wr(8'h18, 32'h4);
        pin(pin_rts, 1'b0);
        for (i = 0; i < 5; i++) u_peer.send(8'hff);
        pin(pin_rts, 1'b1);
        rd(8'h00, 32'h7f);
        pin(pin_rts, 1'b0);
        wr(8'h18, 32'h34);
        pin(pin_rts, 1'b1);
        wr(8'h18, 32'h24);
        pin(pin_rts, 1'b0);
        wr(8'h0c, 32'h80);
        wr(8'h00, 32'h5a);
        wr(8'h04, 32'h3);
        rd(8'h00, 32'h5a);
        rd(8'h04, 32'h3);
        wr(8'h0c, 32'h0);
        rd(8'h04, 32'h0);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
